// File: core/cgpc_check.v
/*
 * call-gate privilege checker with an apb register file.
 * software loads the gate selector, gate and code descriptors, then starts
 * a check; the result, entry address and new privilege level follow.
 * assumes an apb master on ref_clk; no other clock.
 */
// Behaviour
// RULE_01 - gates from global or local tables only
// RULE_02 - gate size sets stack push width
// RULE_03 - target selector and entry come from gate
// RULE_04 - parameter count unit follows gate size
// RULE_05 - clear present flag raises not-present fault
// RULE_06 - pointer offset is stored but never checked
// RULE_07 - entry address is code base plus offset
// RULE_08 - current level must not exceed gate level
// RULE_09 - requester level must not exceed gate level
// RULE_10 - destination checked only after gate checks
// RULE_11 - call to nonconforming allows equal or higher privilege
// RULE_12 - jump to nonconforming needs equal level
// RULE_13 - conforming target allows equal or higher privilege
// RULE_14 - privileged nonconforming call lowers level, switches stack
// RULE_15 - conforming target keeps level, no switch
// RULE_16 - levels 0 to 3, lower is more privileged
// RULE_17 - failed comparison raises general-protection fault
// RULE_18 - at most 31 parameters copied
// RULE_19 - unsigned compares, fault before state update
`timescale 1ns/1ps
`include "cgpc_map.vh"
module cgpc_check #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input  wire              ref_clk,
  input  wire              reset,
  // apb slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  input  wire [3:0]        pstrb,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // check results
  output reg  [1:0]        current_privilege_level,
  output reg               xfer_done,
  output reg               general_protection_fault,
  output reg               not_present_fault,
  output reg               stack_switch_req,
  output reg               push_32bit,
  output reg  [4:0]        param_count,
  output reg  [31:0]       entry_addr,
  output reg  [15:0]       target_sel
);

  // one-hot states
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_GATE = 4'h2;
  localparam [3:0] S_DEST = 4'h4;
  localparam [3:0] S_FIN  = 4'h8;

  // software-loaded operands
  reg [31:0] gate_sel_q;
  reg [31:0] ptr_ofs_q;
  reg [31:0] gate_lo_q;
  reg [31:0] gate_hi_q;
  reg [31:0] code_lo_q;
  reg [31:0] code_hi_q;
  reg        is_call_q;
  reg [1:0]  tbl_q;
  // sequencing and verdict
  reg [3:0]  state_q;
  reg [3:0]  state_d;
  reg        gpf_q;
  reg        npf_q;
  reg        switch_q;
  reg        done_q;
  reg [1:0]  new_pl_q;

  // apply byte strobes to a stored word
  function [31:0] strobe_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      strobe_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strobe_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // descriptor field decode
  // the high offset half counts only for a 32-bit gate
  wire [1:0]  requester_privilege_level       = gate_sel_q[`CGPC_SEL_RPL_HI:`CGPC_SEL_RPL_LO];
  wire [1:0]  gate_dpl  = gate_hi_q[`CGPC_GHI_DPL_HI:`CGPC_GHI_DPL_LO];
  wire        gate_pres = gate_hi_q[`CGPC_GHI_PRESENT];
  wire        gate_32   = gate_hi_q[`CGPC_GHI_SIZE];
  wire        gate_type = !gate_hi_q[`CGPC_GHI_SYS] &&
                          (gate_hi_q[`CGPC_GHI_TYPE_HI:`CGPC_GHI_TYPE_LO] == `CGPC_GATE_TYPE);
  wire [4:0]  gate_pcnt = gate_hi_q[`CGPC_GHI_PCNT_HI:`CGPC_GHI_PCNT_LO];   // RULE_18
  wire [15:0] gate_tsel = gate_lo_q[`CGPC_GLO_SEL_HI:`CGPC_GLO_SEL_LO];     // RULE_03
  wire [15:0] ofs_top   = gate_32 ? gate_hi_q[`CGPC_GHI_OFS_HI:`CGPC_GHI_OFS_LO] : 16'h0000;
  wire [31:0] gate_ofs  = {ofs_top, gate_lo_q[`CGPC_GLO_OFS_HI:0]};         // RULE_03
  wire [1:0]  dest_dpl  = code_hi_q[`CGPC_CHI_DPL_HI:`CGPC_CHI_DPL_LO];
  wire        dest_conf = code_hi_q[`CGPC_CHI_CONFORM];
  wire        dest_code = code_hi_q[`CGPC_CHI_SEG] && code_hi_q[`CGPC_CHI_CODE];
  wire [31:0] code_base = {code_hi_q[`CGPC_CHI_BASE_TOP_HI:`CGPC_CHI_BASE_TOP_LO],
                           code_hi_q[`CGPC_CHI_BASE_MID_HI:0],
                           code_lo_q[`CGPC_CLO_BASE_HI:`CGPC_CLO_BASE_LO]};
  wire [31:0] entry_sum = code_base + gate_ofs;                             // RULE_07
  wire        tbl_ok    = (tbl_q == `CGPC_TBL_GLOBAL) || (tbl_q == `CGPC_TBL_LOCAL); // RULE_01

  // apb phase decode
  wire setup_ph  = psel && !penable;
  wire access_ph = psel && penable && pready;
  wire wr_acc    = access_ph && pwrite;
  wire busy      = !state_q[0];
  wire ctrl_wr   = wr_acc && !busy && (paddr == `CGPC_ADDR_CTRL) && pstrb[0];
  wire start     = ctrl_wr && pwdata[`CGPC_CTRL_START];

  // stage decode, shared by the verdict and result processes
  wire in_gate   = (state_q == S_GATE);
  wire in_dest   = (state_q == S_DEST);
  wire in_fin    = (state_q == S_FIN);

  // privilege comparisons
  wire gate_ok;
  wire dest_ok;
  wire lowers;
  cgpc_cmp u_cmp (
    .cur_pl     (current_privilege_level),
    .req_pl     (requester_privilege_level),
    .gate_dpl   (gate_dpl),
    .dest_dpl   (dest_dpl),
    .is_call    (is_call_q),
    .conforming (dest_conf),
    .gate_ok    (gate_ok),
    .dest_ok    (dest_ok),
    .lowers     (lowers)
  );

  // stage faults; presence is judged only once the gate checks pass
  wire gate_fail = !tbl_ok || !gate_type || !gate_ok;                // RULE_08 RULE_09
  wire dest_fail = !dest_code || !dest_ok;                           // RULE_17

  // next-state logic
  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (start) begin
          state_d = S_GATE;
        end
      end
      S_GATE: begin
        if (gate_fail || !gate_pres) begin
          state_d = S_FIN;
        end else begin
          state_d = S_DEST;                                          // RULE_10
        end
      end
      S_DEST: begin
        state_d = S_FIN;
      end
      S_FIN: begin
        state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
  end

  // state register
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // verdict: faults decided before any level change
  // flags stand until the next start clears them
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gpf_q    <= 1'b0;
      npf_q    <= 1'b0;
      switch_q <= 1'b0;
      done_q   <= 1'b0;
      new_pl_q <= 2'h0;
    end else begin
      if (start) begin
        gpf_q    <= 1'b0;
        npf_q    <= 1'b0;
        switch_q <= 1'b0;
        done_q   <= 1'b0;
      end
      if (in_gate) begin
        if (gate_fail) begin
          gpf_q <= 1'b1;                                             // RULE_01 RULE_17
        end else if (!gate_pres) begin
          npf_q <= 1'b1;                                             // RULE_05
        end
        new_pl_q <= current_privilege_level;
      end
      if (in_dest) begin
        if (dest_fail) begin
          gpf_q <= 1'b1;                                             // RULE_17
        end else if (lowers) begin
          switch_q <= 1'b1;                                          // RULE_14
          new_pl_q <= dest_dpl;
        end
      end
      if (in_fin) begin
        done_q <= 1'b1;
      end
    end
  end

  // result outputs and architectural level
  // a faulting check leaves level and results as they were
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      current_privilege_level  <= 2'h0;
      xfer_done                <= 1'b0;
      general_protection_fault <= 1'b0;
      not_present_fault        <= 1'b0;
      stack_switch_req         <= 1'b0;
      push_32bit               <= 1'b0;
      param_count              <= 5'h00;
      entry_addr               <= 32'h0000_0000;
      target_sel               <= 16'h0000;
    end else begin
      xfer_done                <= 1'b0;
      general_protection_fault <= 1'b0;
      not_present_fault        <= 1'b0;
      stack_switch_req         <= 1'b0;
      if (ctrl_wr) begin
        current_privilege_level <= pwdata[`CGPC_CTRL_CPL_HI:`CGPC_CTRL_CPL_LO];
      end
      if (in_fin) begin
        xfer_done                <= 1'b1;
        general_protection_fault <= gpf_q;
        not_present_fault        <= npf_q;
        if (!gpf_q && !npf_q) begin
          current_privilege_level <= new_pl_q;                       // RULE_14 RULE_15 RULE_19
          stack_switch_req        <= switch_q;
          push_32bit              <= gate_32;                        // RULE_02
          param_count             <= switch_q ? gate_pcnt : 5'h00;   // RULE_04
          entry_addr              <= entry_sum;                      // RULE_07
          target_sel              <= gate_tsel;                      // RULE_03
        end
      end
    end
  end

  // writable registers, locked while a check runs
  // dropping writes while busy keeps operands fixed mid-check
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gate_sel_q <= 32'h0000_0000;
      ptr_ofs_q  <= 32'h0000_0000;
      gate_lo_q  <= 32'h0000_0000;
      gate_hi_q  <= 32'h0000_0000;
      code_lo_q  <= 32'h0000_0000;
      code_hi_q  <= 32'h0000_0000;
      is_call_q  <= 1'b0;
      tbl_q      <= 2'h0;
    end else if (wr_acc && !busy) begin
      case (paddr)
        `CGPC_ADDR_CTRL: begin
          if (pstrb[0]) begin
            is_call_q <= pwdata[`CGPC_CTRL_CALL];
            tbl_q     <= pwdata[`CGPC_CTRL_TBL_HI:`CGPC_CTRL_TBL_LO];
          end
        end
        `CGPC_ADDR_GATE_SEL: gate_sel_q <= strobe_merge(gate_sel_q, pwdata, pstrb);
        `CGPC_ADDR_PTR_OFS:  ptr_ofs_q  <= strobe_merge(ptr_ofs_q, pwdata, pstrb); // RULE_06
        `CGPC_ADDR_GATE_LO:  gate_lo_q  <= strobe_merge(gate_lo_q, pwdata, pstrb);
        `CGPC_ADDR_GATE_HI:  gate_hi_q  <= strobe_merge(gate_hi_q, pwdata, pstrb);
        `CGPC_ADDR_CODE_LO:  code_lo_q  <= strobe_merge(code_lo_q, pwdata, pstrb);
        `CGPC_ADDR_CODE_HI:  code_hi_q  <= strobe_merge(code_hi_q, pwdata, pstrb);
        default: begin
          gate_sel_q <= gate_sel_q;
        end
      endcase
    end
  end

  // status word as read by software
  wire [31:0] status_w;
  assign status_w[`CGPC_ST_BUSY]                     = busy;
  assign status_w[`CGPC_ST_DONE]                     = done_q;
  assign status_w[`CGPC_ST_GPF]                      = gpf_q;
  assign status_w[`CGPC_ST_NPF]                      = npf_q;
  assign status_w[`CGPC_ST_SWITCH]                   = switch_q && done_q;
  assign status_w[`CGPC_ST_PUSH32]                   = push_32bit;
  assign status_w[`CGPC_ST_CPL_HI:`CGPC_ST_CPL_LO]   = current_privilege_level;
  assign status_w[`CGPC_ST_PCNT_HI:`CGPC_ST_PCNT_LO] = param_count;
  assign status_w[31:`CGPC_ST_PCNT_HI+1]             = 19'h00000;

  // read mux and unmapped detection
  reg [31:0] rd_d;
  reg        err_d;
  always @* begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr)
      `CGPC_ADDR_CTRL:     rd_d = {26'h0000000, tbl_q, current_privilege_level, is_call_q, 1'b0};
      `CGPC_ADDR_GATE_SEL: rd_d = gate_sel_q;
      `CGPC_ADDR_PTR_OFS:  rd_d = ptr_ofs_q;
      `CGPC_ADDR_GATE_LO:  rd_d = gate_lo_q;
      `CGPC_ADDR_GATE_HI:  rd_d = gate_hi_q;
      `CGPC_ADDR_CODE_LO:  rd_d = code_lo_q;
      `CGPC_ADDR_CODE_HI:  rd_d = code_hi_q;
      `CGPC_ADDR_STATUS:   rd_d = status_w;
      `CGPC_ADDR_ENTRY:    rd_d = entry_addr;
      `CGPC_ADDR_TGT_SEL:  rd_d = {16'h0000, target_sel};
      default:             err_d = 1'b1;
    endcase
  end

  // apb answer: ready in the first access cycle
  // writes read back zero; unmapped offsets answer with an error
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_d;
      pready  <= 1'b1;
      pslverr <= err_d;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // cgpc_check

// File: core/cgpc_cmp.v
/*
 * privilege comparator for a transfer through a call gate.
 * purely combinational; inputs come from registers of the same clock.
 */
`timescale 1ns/1ps
module cgpc_cmp (
  // privilege levels
  input  wire [1:0] cur_pl,
  input  wire [1:0] req_pl,
  input  wire [1:0] gate_dpl,
  input  wire [1:0] dest_dpl,
  // transfer kind and target kind
  input  wire       is_call,
  input  wire       conforming,
  // verdicts
  output wire       gate_ok,
  output wire       dest_ok,
  output wire       lowers
);

  // unsigned 2-bit less-or-equal
  function le2;
    input [1:0] a;
    input [1:0] b;
    begin
      le2 = (a <= b);
    end
  endfunction

  // caller and selector against the gate level
  assign gate_ok = le2(cur_pl, gate_dpl) && le2(req_pl, gate_dpl); // RULE_08 RULE_09 RULE_16 RULE_19

  // destination level against the caller level
  assign dest_ok = conforming ? le2(dest_dpl, cur_pl) :              // RULE_13
                   is_call    ? le2(dest_dpl, cur_pl) :              // RULE_11
                                (dest_dpl == cur_pl);                // RULE_12

  // only a call into more privileged nonconforming code drops the level
  assign lowers = is_call && !conforming && (dest_dpl < cur_pl);     // RULE_14 RULE_15

endmodule // cgpc_cmp

// File: core/cgpc_map.vh
/*
 * register map, descriptor field positions and encodings for the
 * call-gate privilege checker. assumes byte addresses on a 32-bit apb.
 */
`ifndef CGPC_MAP_VH
`define CGPC_MAP_VH

// register byte addresses
`define CGPC_ADDR_CTRL      8'h00
`define CGPC_ADDR_GATE_SEL  8'h04
`define CGPC_ADDR_PTR_OFS   8'h08
`define CGPC_ADDR_GATE_LO   8'h0c
`define CGPC_ADDR_GATE_HI   8'h10
`define CGPC_ADDR_CODE_LO   8'h14
`define CGPC_ADDR_CODE_HI   8'h18
`define CGPC_ADDR_STATUS    8'h1c
`define CGPC_ADDR_ENTRY     8'h20
`define CGPC_ADDR_TGT_SEL   8'h24

// control register fields
`define CGPC_CTRL_START     0
`define CGPC_CTRL_CALL      1
`define CGPC_CTRL_CPL_LO    2
`define CGPC_CTRL_CPL_HI    3
`define CGPC_CTRL_TBL_LO    4
`define CGPC_CTRL_TBL_HI    5

// table that held the gate
`define CGPC_TBL_GLOBAL     2'h0
`define CGPC_TBL_LOCAL      2'h1
`define CGPC_TBL_INTR       2'h2

// status register fields
`define CGPC_ST_BUSY        0
`define CGPC_ST_DONE        1
`define CGPC_ST_GPF         2
`define CGPC_ST_NPF         3
`define CGPC_ST_SWITCH      4
`define CGPC_ST_PUSH32      5
`define CGPC_ST_CPL_LO      6
`define CGPC_ST_CPL_HI      7
`define CGPC_ST_PCNT_LO     8
`define CGPC_ST_PCNT_HI     12

// selector fields
`define CGPC_SEL_RPL_LO     0
`define CGPC_SEL_RPL_HI     1
`define CGPC_SEL_HI         15

// gate descriptor fields, low word
`define CGPC_GLO_OFS_HI     15
`define CGPC_GLO_SEL_LO     16
`define CGPC_GLO_SEL_HI     31
// gate descriptor fields, high word
`define CGPC_GHI_PCNT_LO    0
`define CGPC_GHI_PCNT_HI    4
`define CGPC_GHI_TYPE_LO    8
`define CGPC_GHI_TYPE_HI    10
`define CGPC_GHI_SIZE       11
`define CGPC_GHI_SYS        12
`define CGPC_GHI_DPL_LO     13
`define CGPC_GHI_DPL_HI     14
`define CGPC_GHI_PRESENT    15
`define CGPC_GHI_OFS_LO     16
`define CGPC_GHI_OFS_HI     31
`define CGPC_GATE_TYPE      3'h4

// code descriptor fields
`define CGPC_CLO_BASE_LO    16
`define CGPC_CLO_BASE_HI    31
`define CGPC_CHI_BASE_MID_HI 7
`define CGPC_CHI_CONFORM    10
`define CGPC_CHI_CODE       11
`define CGPC_CHI_SEG        12
`define CGPC_CHI_DPL_LO     13
`define CGPC_CHI_DPL_HI     14
`define CGPC_CHI_BASE_TOP_LO 24
`define CGPC_CHI_BASE_TOP_HI 31

`endif

// File: test/cgpc_check_sva.sv
/*
 * assertions on the ports of cgpc_check.
 * assumes one clock, ref_clk, and async active-high reset.
 */
`timescale 1ns/1ps
module cgpc_check_sva #(
  parameter ADDR_W = 8
) (
  input logic              ref_clk,
  input logic              reset,
  input logic              psel,
  input logic              penable,
  input logic              pslverr,
  input logic              pready,
  input logic [1:0]        current_privilege_level,
  input logic              xfer_done,
  input logic              general_protection_fault,
  input logic              not_present_fault,
  input logic              stack_switch_req,
  input logic [4:0]        param_count,
  input logic [31:0]       entry_addr,
  input logic [15:0]       target_sel
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // faults come only with the end of a check
  a_gp_with_done: assert property (general_protection_fault |-> xfer_done)
    else $error("gp fault without done");
  a_np_alone: assert property (not_present_fault |-> xfer_done && !general_protection_fault)
    else $error("np fault bad");
  a_switch_lowers: assert property (stack_switch_req |-> xfer_done && !general_protection_fault
    && !not_present_fault && current_privilege_level < $past(current_privilege_level))
    else $error("switch without lower level");
  a_keep_level: assert property (xfer_done && !stack_switch_req |-> $stable(current_privilege_level))
    else $error("level moved without switch");
  a_fault_keeps: assert property (xfer_done && (general_protection_fault || not_present_fault)
    |-> $stable(entry_addr) && $stable(target_sel))
    else $error("results moved on fault");
  a_pcnt_zero: assert property (xfer_done && !stack_switch_req && !general_protection_fault
    && !not_present_fault |-> param_count == 5'h00)
    else $error("count without switch");
  a_done_pulse: assert property (xfer_done |=> !xfer_done)
    else $error("done too long");
  a_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready timing");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("slverr without ready");
  // main scenarios
  c_switch: cover property (stack_switch_req);
  c_gp: cover property (general_protection_fault);
  c_np: cover property (not_present_fault);
  c_err: cover property (pslverr);
endmodule // cgpc_check_sva

bind cgpc_check cgpc_check_sva #(.ADDR_W(ADDR_W)) u_sva (
  .ref_clk                  (ref_clk),
  .reset                    (reset),
  .psel                     (psel),
  .penable                  (penable),
  .pslverr                  (pslverr),
  .pready                   (pready),
  .current_privilege_level  (current_privilege_level),
  .xfer_done                (xfer_done),
  .general_protection_fault (general_protection_fault),
  .not_present_fault        (not_present_fault),
  .stack_switch_req         (stack_switch_req),
  .param_count              (param_count),
  .entry_addr               (entry_addr),
  .target_sel               (target_sel)
);

// File: test/cgpc_dtab.sv
/*
 * descriptor table entries seen by the checker: builds gate and code
 * descriptor words from their fields. assumes the layout in cgpc_map.vh.
 */
`timescale 1ns/1ps
module cgpc_dtab (
  // gate fields
  input  logic [15:0] t_sel,
  input  logic [31:0] t_ofs,
  input  logic        t_pres,
  input  logic [1:0]  t_gdpl,
  input  logic        t_size,
  input  logic [4:0]  t_pcnt,
  // code segment fields
  input  logic [31:0] t_base,
  input  logic [1:0]  t_cdpl,
  input  logic        t_conf,
  // descriptor words
  output logic [31:0] glo,
  output logic [31:0] ghi,
  output logic [31:0] clo,
  output logic [31:0] chi
);
  // gate entry, system type call gate
  assign glo = {t_sel, t_ofs[15:0]};
  assign ghi = {t_ofs[31:16], t_pres, t_gdpl, 1'b0, t_size, 3'h4, 3'h0, t_pcnt};
  // code entry, limit bits arbitrary but never zero
  assign clo = {t_base[15:0], 16'hffff};
  assign chi = {t_base[31:24], 8'h4f, 1'b1, t_cdpl, 2'h3, t_conf, 2'h2, t_base[23:16]};
endmodule // cgpc_dtab

// File: test/tb_top.sv
/*
 * self-checking bench for cgpc_check: apb tasks, checks through gates.
 * assumes cgpc_dtab supplies descriptor words.
 */
`timescale 1ns/1ps
`include "cgpc_map.vh"
module tb_top;
  logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, entry_addr, glo, ghi, clo, chi, rd, t_ofs, t_base;
  logic [31:0] e_ent = 0;
  logic pready, pslverr, xfer_done, general_protection_fault, not_present_fault;
  logic stack_switch_req, push_32bit, er, t_pres, t_size, t_conf, e_p32 = 0;
  logic [1:0] current_privilege_level, t_gdpl, t_cdpl, e_cpl;
  logic [4:0] param_count, t_pcnt, e_pc = 0;
  logic [15:0] target_sel, t_sel, e_sel = 0;
  int n_errors = 0, n_checks = 0;
  int n_done = 0;
  logic [2:0] pulses = 3'h0;
  // clock, 125 MHz
  always #4 ref_clk = ~ref_clk;
  cgpc_check DUT (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .current_privilege_level(current_privilege_level),
    .xfer_done(xfer_done), .general_protection_fault(general_protection_fault),
    .not_present_fault(not_present_fault), .stack_switch_req(stack_switch_req),
    .push_32bit(push_32bit), .param_count(param_count), .entry_addr(entry_addr),
    .target_sel(target_sel)
  );
  cgpc_dtab u_tab (
    .t_sel(t_sel), .t_ofs(t_ofs), .t_pres(t_pres), .t_gdpl(t_gdpl), .t_size(t_size),
    .t_pcnt(t_pcnt), .t_base(t_base), .t_cdpl(t_cdpl), .t_conf(t_conf),
    .glo(glo), .ghi(ghi), .clo(clo), .chi(chi)
  );
  // latch the pulses that close each check
  always @(posedge ref_clk) begin
    if (xfer_done) begin
      n_done <= n_done + 1;
      pulses <= {stack_switch_req, not_present_fault, general_protection_fault};
    end
  end
  task report_and_stop;
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // one apb transfer, result in rd and er
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // load descriptors, start, poll, compare
  task run(input logic c, input logic [1:0] tb, cp, rp, gd, input logic pr, sz,
           input logic [4:0] pc, input logic [1:0] cd, input logic cf);
    logic gp, np, sw;
    int d0;
    gp = tb == `CGPC_TBL_INTR || cp > gd || rp > gd;
    np = !gp && !pr;
    if (!gp && !np) gp = (!cf && !c) ? cd != cp : cd > cp;
    sw = c && !cf && cd < cp && !gp && !np;
    t_sel = {pc, 3'h4, 8'h5a};
    t_ofs = {8'hc3, 3'h0, pc, 16'h1e70};
    t_base = {6'h01, cd, 24'h302000};
    t_pres = pr;
    t_gdpl = gd;
    t_size = sz;
    t_pcnt = pc;
    t_cdpl = cd;
    t_conf = cf;
    #1;
    apb(1'b1, `CGPC_ADDR_GATE_SEL, {30'h0, rp});
    apb(1'b1, `CGPC_ADDR_PTR_OFS, 32'hdeadbeef ^ {27'h0, pc});
    apb(1'b1, `CGPC_ADDR_GATE_LO, glo);
    apb(1'b1, `CGPC_ADDR_GATE_HI, ghi);
    apb(1'b1, `CGPC_ADDR_CODE_LO, clo);
    apb(1'b1, `CGPC_ADDR_CODE_HI, chi);
    d0 = n_done;
    apb(1'b1, `CGPC_ADDR_CTRL, {26'h0, tb, cp, c, 1'b1});
    do begin
      apb(1'b0, `CGPC_ADDR_STATUS, 32'h0);
    end while (rd[0] !== 1'b0);
    chk("status", {27'h0, sw, np, gp, 2'h2}, {27'h0, rd[4:0]});
    chk("done_count", d0 + 1, n_done);
    chk("pulses", {29'h0, sw, np, gp}, {29'h0, pulses});
    e_cpl = sw ? cd : cp;
    if (!gp && !np) begin
      e_ent = t_base + (sz ? t_ofs : {16'h0, t_ofs[15:0]});
      e_sel = t_sel;
      e_p32 = sz;
      e_pc = sw ? pc : 5'h00;
    end
    chk("cpl", {30'h0, e_cpl}, {30'h0, current_privilege_level});
    chk("entry", e_ent, entry_addr);
    chk("result", {10'h0, e_sel, e_p32, e_pc}, {10'h0, target_sel, push_32bit, param_count});
    apb(1'b0, `CGPC_ADDR_ENTRY, 32'h0);
    chk("entry_reg", e_ent, rd);
  endtask
  // watchdog
  initial begin
    #100000;
    n_errors++;
    report_and_stop;
  end
  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    run(1, `CGPC_TBL_GLOBAL, 3, 3, 3, 1, 1, 31, 0, 0);
    run(1, `CGPC_TBL_LOCAL, 2, 1, 3, 1, 0, 7, 1, 0);
    run(0, `CGPC_TBL_GLOBAL, 2, 2, 2, 1, 1, 5, 1, 0);
    run(0, `CGPC_TBL_LOCAL, 1, 0, 3, 1, 0, 5, 1, 0);
    run(1, `CGPC_TBL_GLOBAL, 3, 0, 3, 1, 1, 9, 1, 1);
    run(0, `CGPC_TBL_GLOBAL, 2, 2, 3, 1, 0, 3, 0, 1);
    run(1, `CGPC_TBL_GLOBAL, 1, 1, 3, 1, 1, 3, 2, 1);
    run(1, `CGPC_TBL_GLOBAL, 1, 1, 3, 1, 1, 3, 2, 0);
    run(1, `CGPC_TBL_GLOBAL, 3, 0, 2, 1, 1, 4, 0, 0);
    run(1, `CGPC_TBL_GLOBAL, 0, 3, 2, 1, 1, 4, 0, 0);
    run(1, `CGPC_TBL_GLOBAL, 0, 0, 0, 0, 1, 4, 0, 0);
    run(1, `CGPC_TBL_GLOBAL, 3, 0, 2, 0, 1, 4, 3, 1);
    run(1, `CGPC_TBL_INTR, 0, 0, 3, 1, 1, 4, 0, 0);
    for (int i = 0; i < 4; i++) run(1, `CGPC_TBL_GLOBAL, i, i, 3, 1, 0, 1, i, 0);
    apb(1'b0, 8'h28, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    report_and_stop;
  end
endmodule // tb_top
